//--- hw/plb_block.sv
// Programmable logic block: 64-term AND array, allocator, 8 output cells,
// 8 input cells and 8 three-state pins, configured over Avalon-MM.
// Assumes pins and global clocks are asynchronous to ref_clk and are
// sampled; cell "clocks" are edge events on the 25 MHz clock.
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module plb_block #(
    parameter int TERM_WIDTH = 48
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register bus
    input wire plb_pkg::plb_av_req_t av_req,
    output plb_pkg::plb_av_rsp_t av_rsp,
    // Switch matrix side
    input wire logic [21:0] matrix_in,
    output logic [15:0] internal_feedback,
    output logic [7:0] pin_feedback,
    // Global clock pins
    input wire logic [1:0] global_clock_or_input_pin,
    // Three-state pins, enable low means driven
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n
);
    localparam int NC = plb_pkg::NUM_CELLS;

    typedef struct packed {
        logic [2:0][7:0] pin_s;
        logic [2:0][1:0] gclk_s;
        logic [7:0] pin_q;
        logic [1:0] gclk_q;
        logic [NC-1:0] oc_q;
        logic [NC-1:0] oc_ck_q;
        logic [NC-1:0] ic_q;
        logic [NC-1:0] ic_ck_q;
        logic [NC-1:0] pin_drv;
        logic [NC-1:0] pin_oen;
        plb_pkg::plb_bus_st_t bus_st;
        logic [31:0] rdata;
    } plb_state_t;

    plb_state_t cur_ff;
    plb_state_t nxt_ff;
    logic [TERM_WIDTH-1:0] term_cfg_ff [64];
    logic [31:0] ocfg_ff [NC];
    logic [31:0] icfg_ff [NC];
    // Kept apart from the state struct: one process per variable
    logic [1:0] rst_sync_ff;
    logic rst_n;

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // Product-term array
    logic [plb_pkg::NUM_ARRAY_IN-1:0] arr_in;
    logic [63:0] pterm;
    assign arr_in = {~cur_ff.gclk_q, cur_ff.gclk_q, ~matrix_in, matrix_in};

    genvar gt;
    generate
        for (gt = 0; gt < 64; gt++) begin : g_term
            // All-zero mask means unused term, forced low
            assign pterm[gt] = (|term_cfg_ff[gt]) &&
                ((arr_in & term_cfg_ff[gt]) == term_cfg_ff[gt]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Allocator and output cell datapath
    logic [NC-1:0] oc_sum;
    logic [NC-1:0] oc_ck_raw;
    logic [NC-1:0] oc_clr;
    logic [NC-1:0] oc_set;
    logic [NC-1:0] oc_oe;
    logic [NC-1:0] oc_out;

    genvar gk;
    generate
        for (gk = 0; gk < NC; gk++) begin : g_cell
            logic [11:0] pool;
            logic [2:0] use_clu;
            logic [31:0] cfg;
            assign cfg = ocfg_ff[gk];
            // Ends of the block do not wrap: missing neighbour reads zero
            assign pool[3:0] = (gk == 0) ? 4'h0 :
                pterm[(gk == 0 ? 0 : gk - 1) * 4 +: 4];
            assign pool[7:4] = pterm[gk * 4 +: 4];
            assign pool[11:8] = (gk == NC - 1) ? 4'h0 :
                pterm[(gk == NC - 1 ? gk : gk + 1) * 4 +: 4];
            assign use_clu = cfg[plb_pkg::OC_CLU_LSB +: 3];
            assign oc_sum[gk] = (|(pool[3:0] & {4{use_clu[0]}})) |
                (|(pool[7:4] & {4{use_clu[1]}})) |
                (|(pool[11:8] & {4{use_clu[2]}}));
            // Control terms: clock, clear, set, output enable
            assign oc_ck_raw[gk] = (cfg[plb_pkg::OC_CKSRC_BIT] ?
                cur_ff.gclk_q[0] : pterm[32 + gk * 4]) ^
                cfg[plb_pkg::OC_CKINV_BIT];
            assign oc_clr[gk] = pterm[33 + gk * 4];
            assign oc_set[gk] = pterm[34 + gk * 4];
            assign oc_oe[gk] = pterm[35 + gk * 4];
            assign oc_out[gk] =
                ((cfg[plb_pkg::OC_MODE_LSB +: 2] == plb_pkg::PLB_MODE_COMB) ?
                oc_sum[gk] : cur_ff.oc_q[gk]) ^
                cfg[plb_pkg::OC_POL_BIT];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic [11:0] adr;
        logic [31:0] ocfg;
        logic [31:0] icfg;
        logic ck;
        adr = 12'h000;
        ocfg = 32'h0000_0000;
        icfg = 32'h0000_0000;
        ck = 1'b0;
        nxt_ff = cur_ff;
        // Three-stage pin sampling; change counts once stages 2 and 3 agree
        nxt_ff.pin_s = {cur_ff.pin_s[1:0], pin_in};
        nxt_ff.gclk_s = {cur_ff.gclk_s[1:0], global_clock_or_input_pin};
        for (int i = 0; i < NC; i++) begin
            if (cur_ff.pin_s[1][i] == cur_ff.pin_s[2][i]) begin
                nxt_ff.pin_q[i] = cur_ff.pin_s[2][i];
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (cur_ff.gclk_s[1][i] == cur_ff.gclk_s[2][i]) begin
                nxt_ff.gclk_q[i] = cur_ff.gclk_s[2][i];
            end
        end
        // Output cells, each with its own clock, clear and set
        for (int i = 0; i < NC; i++) begin
            ocfg = ocfg_ff[i];
            nxt_ff.oc_ck_q[i] = oc_ck_raw[i];
            if (oc_clr[i]) begin
                nxt_ff.oc_q[i] = 1'b0;
            end else if (oc_set[i]) begin
                nxt_ff.oc_q[i] = 1'b1;
            end else if (ocfg[plb_pkg::OC_MODE_LSB +: 2] ==
                    plb_pkg::PLB_MODE_LATCH) begin
                // Gate active while the polarity-adjusted clock (term or gclk_q[0]) is high
                if (oc_ck_raw[i]) begin
                    nxt_ff.oc_q[i] = oc_sum[i];
                end
            end else if (ocfg[plb_pkg::OC_MODE_LSB +: 2] ==
                    plb_pkg::PLB_MODE_REG) begin
                if (oc_ck_raw[i] && !cur_ff.oc_ck_q[i]) begin
                    if (ocfg[plb_pkg::OC_TOGGLE_BIT]) begin
                        nxt_ff.oc_q[i] = cur_ff.oc_q[i] ^ oc_sum[i];
                    end else begin
                        nxt_ff.oc_q[i] = oc_sum[i];
                    end
                end
            end
            nxt_ff.pin_drv[i] = oc_out[i];
            nxt_ff.pin_oen[i] = ~oc_oe[i];
        end
        // Input cells: no clear or set exists here
        for (int i = 0; i < NC; i++) begin
            icfg = icfg_ff[i];
            ck = (icfg[plb_pkg::IC_CKSEL_BIT] ? cur_ff.gclk_q[1] :
                cur_ff.gclk_q[0]) ^ icfg[plb_pkg::IC_CKINV_BIT];
            nxt_ff.ic_ck_q[i] = ck;
            if (icfg[plb_pkg::IC_LATCH_BIT]) begin
                if (ck) begin
                    nxt_ff.ic_q[i] = cur_ff.pin_q[i];
                end
            end else if (ck && !cur_ff.ic_ck_q[i]) begin
                nxt_ff.ic_q[i] = cur_ff.pin_q[i];
            end
        end
        // Bus slave: one cycle of wait, answer in the second
        adr = av_req.address;
        case (cur_ff.bus_st)
            plb_pkg::PLB_BUS_IDLE: begin
                if (av_req.read || av_req.write) begin
                    nxt_ff.bus_st = plb_pkg::PLB_BUS_ANSWER;
                    if (adr <= plb_pkg::ADR_TERM_LAST) begin
                        nxt_ff.rdata = 32'(term_cfg_ff[adr[7:2]]);
                    end else if (adr >= plb_pkg::ADR_OCFG_BASE &&
                            adr <= plb_pkg::ADR_OCFG_LAST) begin
                        nxt_ff.rdata = ocfg_ff[adr[4:2]];
                    end else if (adr >= plb_pkg::ADR_ICFG_BASE &&
                            adr <= plb_pkg::ADR_ICFG_LAST) begin
                        nxt_ff.rdata = icfg_ff[adr[4:2]];
                    end else if (adr == plb_pkg::ADR_STATUS) begin
                        nxt_ff.rdata = {16'h0000, cur_ff.ic_q, cur_ff.oc_q};
                    end else if (adr == plb_pkg::ADR_FEEDBACK) begin
                        nxt_ff.rdata = {8'h00, pin_feedback,
                            internal_feedback};
                    end else begin
                        nxt_ff.rdata = plb_pkg::UNMAPPED_READ;
                    end
                end
            end
            plb_pkg::PLB_BUS_ANSWER: begin
                nxt_ff.bus_st = plb_pkg::PLB_BUS_IDLE;
            end
            default: begin
                nxt_ff.bus_st = plb_pkg::PLB_BUS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; everything starts low except the pin enables (pin_oen), which start high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff.pin_s <= '0;
            cur_ff.gclk_s <= '0;
            cur_ff.pin_q <= '0;
            cur_ff.gclk_q <= '0;
            cur_ff.oc_q <= '0;
            cur_ff.oc_ck_q <= '0;
            cur_ff.ic_q <= '0;
            cur_ff.ic_ck_q <= '0;
            cur_ff.pin_drv <= '0;
            cur_ff.pin_oen <= '1;
            cur_ff.bus_st <= plb_pkg::PLB_BUS_IDLE;
            cur_ff.rdata <= 32'h0000_0000;
        end else begin
            cur_ff.pin_s <= nxt_ff.pin_s;
            cur_ff.gclk_s <= nxt_ff.gclk_s;
            cur_ff.pin_q <= nxt_ff.pin_q;
            cur_ff.gclk_q <= nxt_ff.gclk_q;
            cur_ff.oc_q <= nxt_ff.oc_q;
            cur_ff.oc_ck_q <= nxt_ff.oc_ck_q;
            cur_ff.ic_q <= nxt_ff.ic_q;
            cur_ff.ic_ck_q <= nxt_ff.ic_ck_q;
            cur_ff.pin_drv <= nxt_ff.pin_drv;
            cur_ff.pin_oen <= nxt_ff.pin_oen;
            cur_ff.bus_st <= nxt_ff.bus_st;
            cur_ff.rdata <= nxt_ff.rdata;
        end
    end

    // Config store; writes land only at the answering edge
    logic wr_now;
    assign wr_now = (cur_ff.bus_st == plb_pkg::PLB_BUS_ANSWER) &&
        av_req.write;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 64; i++) begin
                term_cfg_ff[i] <= plb_pkg::TERM_RESET[TERM_WIDTH-1:0];
            end
            for (int i = 0; i < NC; i++) begin
                ocfg_ff[i] <= plb_pkg::CFG_RESET;
                icfg_ff[i] <= plb_pkg::CFG_RESET;
            end
        end else if (wr_now) begin
            // Term masks wider than 32 bits take the write in the low word
            if (av_req.address <= plb_pkg::ADR_TERM_LAST) begin
                term_cfg_ff[av_req.address[7:2]] <=
                    TERM_WIDTH'(av_req.writedata);
            end else if (av_req.address >= plb_pkg::ADR_OCFG_BASE &&
                    av_req.address <= plb_pkg::ADR_OCFG_LAST) begin
                ocfg_ff[av_req.address[4:2]] <= av_req.writedata;
            end else if (av_req.address >= plb_pkg::ADR_ICFG_BASE &&
                    av_req.address <= plb_pkg::ADR_ICFG_LAST) begin
                icfg_ff[av_req.address[4:2]] <= av_req.writedata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign av_rsp.waitrequest = (cur_ff.bus_st != plb_pkg::PLB_BUS_ANSWER);
    assign av_rsp.readdata = cur_ff.rdata;
    assign internal_feedback = {cur_ff.ic_q, oc_out};
    assign pin_feedback = cur_ff.pin_q;
    assign pin_out = cur_ff.pin_drv;
    assign pin_oe_n = cur_ff.pin_oen;

    // Block sizes fixed by construction
    if (plb_pkg::NUM_INPUTS != 22 || NC != 8) begin : g_size_chk
        $error("block size mismatch");
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_clear_wins;
        @(posedge ref_clk) disable iff (!rst_n)
        oc_clr[0] |=> !cur_ff.oc_q[0];
    endproperty
    a_clear_wins: assert property (p_clear_wins)
        else $error("clear did not clear cell");

    property p_set_alone;
        @(posedge ref_clk) disable iff (!rst_n)
        (oc_set[0] && !oc_clr[0]) |=> cur_ff.oc_q[0];
    endproperty
    a_set_alone: assert property (p_set_alone)
        else $error("set did not set cell");

    property p_toggle;
        @(posedge ref_clk) disable iff (!rst_n)
        (ocfg_ff[0][1:0] == 2'h1 && ocfg_ff[0][2] && oc_sum[0] &&
         oc_ck_raw[0] && !cur_ff.oc_ck_q[0] && !oc_clr[0] && !oc_set[0])
        |=> cur_ff.oc_q[0] != $past(cur_ff.oc_q[0]);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle cell did not invert");

    property p_dreg_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (ocfg_ff[0][1:0] == 2'h1 && !(oc_ck_raw[0] && !cur_ff.oc_ck_q[0])
         && !oc_clr[0] && !oc_set[0]) |=> $stable(cur_ff.oc_q[0]);
    endproperty
    a_dreg_hold: assert property (p_dreg_hold)
        else $error("register changed without edge");

    property p_latch_pass;
        @(posedge ref_clk) disable iff (!rst_n)
        (ocfg_ff[0][1:0] == 2'h2 && oc_ck_raw[0] && !oc_clr[0] && !oc_set[0])
        |=> cur_ff.oc_q[0] == $past(oc_sum[0]);
    endproperty
    a_latch_pass: assert property (p_latch_pass)
        else $error("latch not transparent");

    property p_comb_out;
        @(posedge ref_clk) disable iff (!rst_n)
        ocfg_ff[0][1:0] == 2'h0 |-> oc_out[0] == (oc_sum[0] ^ ocfg_ff[0][3]);
    endproperty
    a_comb_out: assert property (p_comb_out)
        else $error("combinational output wrong");

    property p_pin_enable;
        @(posedge ref_clk) disable iff (!rst_n)
        oc_oe[0] |=> !pin_oe_n[0] && pin_out[0] == $past(oc_out[0]);
    endproperty
    a_pin_enable: assert property (p_pin_enable)
        else $error("pin not driven when enabled");

    property p_feedback;
        @(posedge ref_clk) disable iff (!rst_n)
        internal_feedback[7:0] == oc_out;
    endproperty
    a_feedback: assert property (p_feedback)
        else $error("feedback lost");

    property p_input_latch;
        @(posedge ref_clk) disable iff (!rst_n)
        (icfg_ff[1][0] && icfg_ff[1][1] && (cur_ff.gclk_q[1] ^ icfg_ff[1][2]))
        |=> cur_ff.ic_q[1] == $past(cur_ff.pin_q[1]);
    endproperty
    a_input_latch: assert property (p_input_latch)
        else $error("input latch not transparent");

    property p_bus_answer;
        @(posedge ref_clk) disable iff (!rst_n)
        (av_req.read && cur_ff.bus_st == plb_pkg::PLB_BUS_IDLE)
        |=> !av_rsp.waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer late");
endmodule : plb_block
`default_nettype wire

//--- hw/plb_pkg.sv
// Package for the programmable logic block: sizes, configuration layout,
// config register map and bus carriers.
// Assumes a single 25 MHz clock domain; no imports anywhere.
package plb_pkg;
    localparam int NUM_CELLS = 8;
    localparam int NUM_INPUTS = 22;
    localparam int NUM_LOGIC_TERMS = 32;
    localparam int NUM_CTRL_TERMS = 32;
    localparam int TERMS_PER_CLUSTER = 4;
    localparam int NUM_CLUSTERS = 8;
    localparam int NUM_ARRAY_IN = 2 * (NUM_INPUTS + 2);
    localparam int NUM_IFB = 2 * NUM_CELLS;
    // Per output cell config word layout
    localparam int OC_MODE_LSB = 0;
    localparam int OC_TOGGLE_BIT = 2;
    localparam int OC_POL_BIT = 3;
    localparam int OC_CKSRC_BIT = 4;
    localparam int OC_CKINV_BIT = 5;
    localparam int OC_CLU_LSB = 8;
    // Per input cell config word layout
    localparam int IC_LATCH_BIT = 0;
    localparam int IC_CKSEL_BIT = 1;
    localparam int IC_CKINV_BIT = 2;
    // Register word offsets (byte addresses)
    localparam logic [11:0] ADR_TERM_BASE = 12'h000;
    localparam logic [11:0] ADR_TERM_LAST = 12'h0FC;
    localparam logic [11:0] ADR_OCFG_BASE = 12'h100;
    localparam logic [11:0] ADR_OCFG_LAST = 12'h11C;
    localparam logic [11:0] ADR_ICFG_BASE = 12'h200;
    localparam logic [11:0] ADR_ICFG_LAST = 12'h21C;
    localparam logic [11:0] ADR_STATUS = 12'h300;
    localparam logic [11:0] ADR_FEEDBACK = 12'h304;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    localparam logic [47:0] TERM_RESET = 48'h0000_0000_0000;

    typedef enum logic [1:0] {
        PLB_MODE_COMB = 2'h0,
        PLB_MODE_REG = 2'h1,
        PLB_MODE_LATCH = 2'h2
    } plb_mode_t;

    typedef enum logic [1:0] {
        PLB_BUS_IDLE = 2'h0,
        PLB_BUS_ANSWER = 2'h1
    } plb_bus_st_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [11:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } plb_av_req_t;

    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } plb_av_rsp_t;
endpackage : plb_pkg

//--- sim/plb_block_bench.sv
// Self-checking bench for the logic block: registers over Avalon-MM,
// cell behaviour seen at the feedback outputs and the pins.
// Assumes plb_board resolves the pins; one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module plb_block_bench;
    logic ref_clk = 1'b0;
    logic nrst;
    plb_pkg::plb_av_req_t av_req;
    plb_pkg::plb_av_rsp_t av_rsp;
    logic [21:0] matrix_in;
    logic [15:0] internal_feedback;
    logic [7:0] pin_feedback, pin_level, pin_out, pin_oe_n;
    logic [7:0] board_val, board_en;
    logic [1:0] gclk;
    logic [31:0] q;
    int miscompares = 0;
    int cmp_count = 0;

    plb_block dut (.ref_clk(ref_clk), .nrst(nrst), .av_req(av_req),
        .av_rsp(av_rsp), .matrix_in(matrix_in),
        .internal_feedback(internal_feedback), .pin_feedback(pin_feedback),
        .global_clock_or_input_pin(gclk), .pin_in(pin_level),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    plb_board board (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .board_val(board_val), .board_en(board_en), .pin_level(pin_level));

    always #20 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] want,
                       input string what);
        cmp_count++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD t=%0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask : chk

    // Request held until waitrequest is sampled low; the watchdog ends a hang
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rdata);
        av_req.read <= !wr;
        av_req.write <= wr;
        av_req.address <= a;
        av_req.writedata <= d;
        do begin
            @(posedge ref_clk);
        end while (av_rsp.waitrequest !== 1'b0);
        rdata = av_rsp.readdata;
        av_req.read <= 1'b0;
        av_req.write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus

    task automatic term(input int i, input int b);
        bus(1'b1, plb_pkg::ADR_TERM_BASE + 12'(4 * i), 32'h1 << b, q);
    endtask : term

    task automatic ocfg(input int k, input logic [31:0] d);
        bus(1'b1, plb_pkg::ADR_OCFG_BASE + 12'(4 * k), d, q);
    endtask : ocfg

    task automatic do_reset();
        nrst <= 1'b0;
        matrix_in <= 22'h000000;
        gclk <= 2'h0;
        board_en <= 8'h00;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask : do_reset

    // Pin path is 4 edges (5 through pin_drv); six covers it and the cell update
    task automatic step(input logic [7:0] v, input logic [7:0] m,
                        input logic [7:0] e);
        matrix_in <= 22'(v);
        repeat (6) @(posedge ref_clk);
        chk(32'(internal_feedback[7:0] & m), 32'(e), "cell out");
    endtask : step

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        do_reset();
        repeat (4) @(posedge ref_clk);
        chk(32'(internal_feedback), 32'h0, "fb after reset");
        chk(32'(pin_oe_n), 32'hFF, "oe after reset");
        chk(32'(pin_feedback), 32'hFF, "pull-up pins");
        bus(1'b0, plb_pkg::ADR_OCFG_BASE, 32'h0, q);
        chk(q, plb_pkg::CFG_RESET, "cfg reset");
        bus(1'b0, 12'h400, 32'h0, q);
        chk(q, plb_pkg::UNMAPPED_READ, "unmapped read");
    endtask : t_reset

    task automatic t_clusters();
        do_reset();
        term(0, 0);
        term(28, 5);
        for (int k = 0; k < 8; k++) ocfg(k, 32'h0000_0700);
        step(8'h01, 8'hFF, 8'h03);
        ocfg(0, 32'h0000_0708);
        step(8'h21, 8'hFF, 8'hC2);
    endtask : t_clusters

    task automatic t_register();
        do_reset();
        term(0, 0);
        term(32, 1);
        ocfg(0, 32'h0000_0201);
        step(8'h01, 8'h01, 8'h00);
        step(8'h03, 8'h01, 8'h01);
        step(8'h02, 8'h01, 8'h01);
        step(8'h00, 8'h01, 8'h01);
        step(8'h02, 8'h01, 8'h00);
        ocfg(0, 32'h0000_0205);
        step(8'h01, 8'h01, 8'h00);
        step(8'h03, 8'h01, 8'h01);
        step(8'h01, 8'h01, 8'h01);
        step(8'h03, 8'h01, 8'h00);
        step(8'h00, 8'h01, 8'h00);
        step(8'h02, 8'h01, 8'h00);
        ocfg(0, 32'h0000_0221);
        step(8'h03, 8'h01, 8'h00);
        step(8'h01, 8'h01, 8'h01);
        step(8'h02, 8'h01, 8'h01);
    endtask : t_register

    task automatic t_clear_set();
        do_reset();
        term(33, 2);
        term(34, 3);
        ocfg(0, 32'h0000_0201);
        ocfg(1, 32'h0000_0201);
        step(8'h08, 8'h03, 8'h01);
        bus(1'b0, plb_pkg::ADR_STATUS, 32'h0, q);
        chk(q, 32'h0000_0001, "status word");
        bus(1'b0, plb_pkg::ADR_FEEDBACK, 32'h0, q);
        chk(q, 32'h00FF_0001, "feedback word");
        step(8'h00, 8'h03, 8'h01);
        step(8'h04, 8'h03, 8'h00);
        step(8'h08, 8'h03, 8'h01);
        step(8'h0C, 8'h03, 8'h00);
    endtask : t_clear_set

    task automatic t_latch();
        do_reset();
        term(0, 0);
        term(32, 1);
        ocfg(0, 32'h0000_0202);
        step(8'h03, 8'h01, 8'h01);
        step(8'h01, 8'h01, 8'h01);
        step(8'h00, 8'h01, 8'h01);
        step(8'h02, 8'h01, 8'h00);
        ocfg(0, 32'h0000_0222);
        step(8'h01, 8'h01, 8'h01);
        step(8'h03, 8'h01, 8'h01);
        step(8'h02, 8'h01, 8'h01);
        step(8'h00, 8'h01, 8'h00);
    endtask : t_latch

    task automatic t_global();
        do_reset();
        term(0, 0);
        ocfg(0, 32'h0000_0211);
        bus(1'b1, plb_pkg::ADR_ICFG_BASE + 12'h004, 32'h0000_0007, q);
        board_en <= 8'h03;
        board_val <= 8'h03;
        step(8'h01, 8'h01, 8'h00);
        chk(32'(internal_feedback[9:8]), 32'h2, "in cells idle");
        gclk <= 2'h3;
        step(8'h01, 8'h01, 8'h01);
        chk(32'(internal_feedback[9:8]), 32'h3, "in reg edge");
        board_val <= 8'h00;
        step(8'h01, 8'h01, 8'h01);
        chk(32'(internal_feedback[9:8]), 32'h3, "in hold");
        gclk <= 2'h0;
        step(8'h00, 8'h01, 8'h01);
        chk(32'(internal_feedback[9:8]), 32'h1, "in latch open");
    endtask : t_global

    task automatic t_pins();
        do_reset();
        term(0, 0);
        term(35, 4);
        ocfg(0, 32'h0000_0200);
        step(8'h11, 8'h01, 8'h01);
        chk(32'(pin_oe_n), 32'hFE, "oe own term");
        chk(32'(pin_feedback[0]), 32'h1, "pin drive 1");
        chk(32'(pin_out[0]), 32'h1, "pin drive value");
        step(8'h10, 8'h01, 8'h00);
        chk(32'(pin_feedback[0]), 32'h0, "pin drive 0");
        step(8'h00, 8'h01, 8'h00);
        chk(32'(pin_oe_n), 32'hFF, "pin released");
        chk(32'(pin_feedback[0]), 32'h1, "pin pulled up");
    endtask : t_pins

    ////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        av_req = '0;
        av_req.byteenable = 4'hF;
        matrix_in = 22'h000000;
        gclk = 2'h0;
        board_val = 8'h00;
        board_en = 8'h00;
        t_reset();
        t_clusters();
        t_register();
        t_clear_set();
        t_latch();
        t_global();
        t_pins();
        stop_test();
    end

    // Tests take a few hundred cycles; about a hundred times that means a hang
    initial begin
        repeat (40000) @(posedge ref_clk);
        miscompares++;
        stop_test();
    end
endmodule : plb_block_bench
`default_nettype wire

//--- sim/plb_board.sv
// Board-side model of the eight three-state pins of the logic block.
// Assumes the block drives a pin while its enable is low; the board
// drives only where the bench enables it, otherwise the pull-up wins.
`timescale 1ns/1ps
`default_nettype none
module plb_board (
    // Block side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    // Board drive
    input wire logic [7:0] board_val,
    input wire logic [7:0] board_en,
    // Resolved pin level
    output logic [7:0] pin_level
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin_level[i] = pin_out[i];
            end else if (board_en[i]) begin
                pin_level[i] = board_val[i];
            end else begin
                // Released pins float high on the pull-up, never stale
                pin_level[i] = 1'b1;
            end
        end
    end
endmodule : plb_board
`default_nettype wire
